// ### common/mia_consts.svh
// Register offsets, field positions and reset values of the interrupt acceptance block.
// Included by the testbench and by the design modules; definitions only.
`ifndef MIA_CONSTS_SVH
`define MIA_CONSTS_SVH

// ==========================================================
// Register map (byte addresses, one word each)
`define MIA_OFF_GLOBAL      12'h000
`define MIA_OFF_THRESHOLD   12'h004
`define MIA_OFF_STATUS      12'h008
`define MIA_OFF_MASK        12'h00c
`define MIA_OFF_ACCEPT      12'h010
`define MIA_OFF_CTRL_BASE   12'h040

// ==========================================================
// Source control register fields
`define MIA_FLD_PRIO_LSB    0
`define MIA_FLD_PRIO_MSB    2
`define MIA_FLD_REQ         3
`define MIA_FLD_POL         4
`define MIA_FLD_SENSE       5

// ==========================================================
// Status and mask bit positions
`define MIA_EVT_REQ         0
`define MIA_EVT_ACC         1

// ==========================================================
// Reset values
`define MIA_RST_CTRL        8'h00
`define MIA_RST_THRESHOLD   3'h0
`define MIA_RST_GLOBAL      1'b0
`define MIA_RST_MASK        2'h0

`endif

// ### common/mia_pkg.sv
// Types shared by the interrupt acceptance block.
// Assumes mia_consts.svh is on the include path.
package mia_pkg;
	typedef logic [2:0] mia_level_t;
	typedef logic [7:0] mia_ctrl_t;
	typedef enum logic [1:0] {
		MIA_IDLE,
		MIA_OFFER
	} mia_state_t;
endpackage

// ### verif/mia_core_model.sv
// Processor core model: acknowledges an offered request after a set delay.
// Assumes irq_valid comes from the acceptor on the same hclk.
`timescale 1ns/1ps
module mia_core_model (
	input  wire logic       hclk,
	input  wire logic       hresetn,
	input  wire logic       irq_valid,
	input  wire logic       ack_en,
	input  wire logic [3:0] ack_dly,
	output logic            cpu_ack
);
	logic [3:0] wait_ff;
	// ==========================================
	// Ack pulse
	// Count restarts if the offer is withdrawn, so a stale offer is never taken
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wait_ff <= 4'h0;
			cpu_ack <= 1'b0;
		end else begin
			cpu_ack <= 1'b0;
			if (!irq_valid || !ack_en || cpu_ack) begin
				wait_ff <= 4'h0;
			end else if (wait_ff == ack_dly) begin
				cpu_ack <= 1'b1;
				wait_ff <= 4'h0;
			end else begin
				wait_ff <= wait_ff + 4'h1;
			end
		end
	end
endmodule

// ### verif/testbench.sv
// Self-checking bench of the acceptor: AHB-Lite master, sources, core model.
// Assumes a zero-wait slave; sources driven synchronously to hclk.
`timescale 1ns/1ps
`include "mia_consts.svh"
module testbench;
	import mia_pkg::*;
	logic        hclk;
	logic        hresetn;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic [7:0]  src_in;
	logic        cpu_ack;
	logic        ack_en;
	logic        irq_valid;
	logic [7:0]  irq_source;
	mia_level_t  irq_level;
	logic        irq_out;
	int          mismatches;
	int          checked;
	int          cyc = 0;

	mia_acceptor #(.N_SRC(8)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.src_in(src_in), .cpu_ack(cpu_ack), .irq_valid(irq_valid),
		.irq_source(irq_source), .irq_level(irq_level), .irq_out(irq_out));
	mia_core_model core (.hclk(hclk), .hresetn(hresetn), .irq_valid(irq_valid),
		.ack_en(ack_en), .ack_dly(4'h2), .cpu_ack(cpu_ack));

	initial begin
		hclk = 1'b0;
		forever #2.5 hclk = ~hclk;
	end

	// ==========================================
	// Shared tasks
	task end_sim;
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task bus(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge hclk);
		haddr <= {20'h0, a};
		htrans <= 2'b10;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task rc(input logic [11:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(q, e);
	endtask
	task pause(input int n);
		repeat (n) @(posedge hclk);
		#1;
	endtask
	task src(input int i, input logic v);
		@(posedge hclk);
		src_in[i] <= v;
		pause(3);
	endtask
	function automatic logic [11:0] ca(input int i);
		return `MIA_OFF_CTRL_BASE + 12'(4 * i);
	endfunction

	// ==========================================
	// Scenarios
	task t_reset;
		chk(irq_valid, 1'b0);
		chk(irq_out, 1'b0);
		chk(hresp, 1'b0);
		chk(hreadyout, 1'b1);
		rc(`MIA_OFF_GLOBAL, 32'h0);
		rc(`MIA_OFF_THRESHOLD, 32'h0);
		rc(`MIA_OFF_MASK, 32'h0);
		rc(`MIA_OFF_STATUS, 32'h0);
		rc(ca(0), 32'h0);
		rc(ca(4), 32'h0);
		rc(ca(5), 32'h0);
		wr(12'h020, 32'hffffffff);
		rc(12'h020, 32'h0);
		$display("test reset finished");
	endtask
	task t_edge;
		wr(ca(0), 32'h13);
		src(0, 1'b1);
		rc(ca(0), 32'h1b);
		wr(ca(0), 32'h13);
		rc(ca(0), 32'h13);
		wr(ca(0), 32'h1b);
		rc(ca(0), 32'h13);
		src(0, 1'b0);
		rc(ca(0), 32'h13);
		wr(ca(0), 32'h03);
		src(0, 1'b1);
		rc(ca(0), 32'h03);
		src(0, 1'b0);
		rc(ca(0), 32'h0b);
		wr(ca(0), 32'h13);
		rc(ca(0), 32'h13);
		$display("test edge finished");
	endtask
	task t_gate;
		src(0, 1'b1);
		chk(irq_valid, 1'b0);
		wr(`MIA_OFF_GLOBAL, 32'h1);
		pause(2);
		chk(irq_valid, 1'b1);
		chk(irq_level, 3'h3);
		chk(irq_source, 8'h0);
		for (int t = 0; t < 8; t++) begin
			wr(`MIA_OFF_THRESHOLD, 32'(t));
			pause(2);
			chk(irq_valid, 32'(3 > t));
		end
		rc(ca(0), 32'h1b);
		rc(`MIA_OFF_GLOBAL, 32'h1);
		wr(`MIA_OFF_THRESHOLD, 32'h3);
		for (int p = 0; p < 8; p++) begin
			wr(ca(0), 32'h18 | 32'(p));
			pause(2);
			chk(irq_valid, 32'(p > 3));
			if (p > 3) chk(irq_level, 32'(p));
		end
		rc(`MIA_OFF_THRESHOLD, 32'h3);
		wr(`MIA_OFF_GLOBAL, 32'h0);
		pause(2);
		chk(irq_valid, 1'b0);
		wr(ca(0), 32'h10);
		wr(`MIA_OFF_THRESHOLD, 32'h0);
		wr(`MIA_OFF_GLOBAL, 32'h1);
		$display("test gate finished");
	endtask
	task t_accept;
		wr(ca(1), 32'h15);
		wr(ca(2), 32'h16);
		src(1, 1'b1);
		src(2, 1'b1);
		chk(irq_source, 8'h2);
		chk(irq_level, 3'h6);
		@(posedge hclk);
		ack_en <= 1'b1;
		for (int i = 0; i < 20 && cpu_ack !== 1'b1; i++) @(posedge hclk);
		ack_en <= 1'b0;
		pause(3);
		chk(irq_source, 8'h1);
		chk(irq_level, 3'h5);
		rc(ca(2), 32'h16);
		rc(ca(1), 32'h1d);
		rc(`MIA_OFF_ACCEPT, 32'h2);
		wr(ca(1), 32'h0);
		wr(ca(2), 32'h0);
		$display("test accept finished");
	endtask
	task t_irq;
		logic [31:0] q;
		bus(1'b0, `MIA_OFF_STATUS, 32'h0, q);
		rc(`MIA_OFF_STATUS, 32'h0);
		wr(`MIA_OFF_MASK, 32'h1);
		wr(ca(3), 32'h23);
		pause(2);
		rc(ca(3), 32'h23);
		src(3, 1'b0);
		rc(ca(3), 32'h2b);
		chk(irq_out, 1'b1);
		wr(ca(3), 32'h23);
		rc(ca(3), 32'h2b);
		src(3, 1'b1);
		wr(ca(3), 32'h23);
		rc(ca(3), 32'h23);
		rc(`MIA_OFF_STATUS, 32'h1);
		pause(1);
		chk(irq_out, 1'b0);
		wr(`MIA_OFF_MASK, 32'h0);
		src(3, 1'b0);
		chk(irq_out, 1'b0);
		rc(`MIA_OFF_STATUS, 32'h1);
		src(3, 1'b1);
		wr(ca(3), 32'h0);
		$display("test irq finished");
	endtask

	// ==========================================
	// Main sequence and timeout
	initial begin
		hresetn = 1'b0;
		hsel = 1'b1;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		src_in = 8'h08;
		ack_en = 1'b0;
		mismatches = 0;
		checked = 0;
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		pause(1);
		t_reset;
		t_edge;
		t_gate;
		t_accept;
		t_irq;
		end_sim;
	end
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 5000) begin
			mismatches++;
			end_sim;
		end
	end
endmodule

// ### verilog/mia_acceptor.sv
// Maskable interrupt acceptance: per-source control registers, global enable,
// processor threshold, highest-level selection, AHB-Lite register slave.
// Assumes AHB-Lite single word transfers and a core that pulses cpu_ack.
`timescale 1ns/1ps
`include "mia_consts.svh"
module mia_acceptor
	import mia_pkg::*;
#(
	parameter int N_SRC = 8
) (
	input  wire logic                 hclk,
	input  wire logic                 hresetn,
	input  wire logic                 hsel,
	input  wire logic [31:0]          haddr,
	input  wire logic [1:0]           htrans,
	input  wire logic                 hwrite,
	input  wire logic [2:0]           hsize,
	input  wire logic [31:0]          hwdata,
	input  wire logic                 hready,
	output logic      [31:0]          hrdata,
	output logic                      hreadyout,
	output logic                      hresp,
	input  wire logic [N_SRC-1:0]     src_in,
	input  wire logic                 cpu_ack,
	output logic                      irq_valid,
	output logic      [7:0]           irq_source,
	output mia_pkg::mia_level_t       irq_level,
	output logic                      irq_out
);
	import mia_pkg::*;

	mia_ctrl_t        ctrl_ff [N_SRC];
	logic             global_en_ff;
	mia_level_t       threshold_ff;
	logic [1:0]       status_ff;
	logic [1:0]       mask_ff;
	logic [7:0]       acc_src_ff;
	mia_state_t       state_ff;
	logic [7:0]       irq_source_ff;
	mia_level_t       irq_level_ff;
	logic             wr_pend_ff;
	logic             rd_pend_ff;
	logic [11:0]      addr_ff;
	logic [31:0]      hrdata_ff;
	logic [N_SRC-1:0] req_pulse;
	logic [N_SRC-1:0] pol_vec;
	logic [N_SRC-1:0] sense_vec;
	logic             best_found;
	logic [7:0]       best_src;
	mia_level_t       best_level;
	logic             addr_phase;
	logic             take_ack;
	logic             any_req;
	logic             offer_ok;
	logic [N_SRC-1:0] pend_vec;
	logic [N_SRC-1:0] ack_hit;

	// ==========================================================
	// Helpers
	function automatic mia_level_t level_of(input mia_ctrl_t c);
		level_of = c[`MIA_FLD_PRIO_MSB:`MIA_FLD_PRIO_LSB];
	endfunction

	function automatic logic is_ctrl(input logic [11:0] a);
		is_ctrl = (a >= `MIA_OFF_CTRL_BASE) &&
			(a < `MIA_OFF_CTRL_BASE + 12'(N_SRC * 4));
	endfunction

	function automatic int ctrl_idx(input logic [11:0] a);
		ctrl_idx = int'((a - `MIA_OFF_CTRL_BASE) >> 2);
	endfunction

	// ==========================================================
	// Request detection
	always_comb begin
		for (int i = 0; i < N_SRC; i++) begin
			pol_vec[i]   = ctrl_ff[i][`MIA_FLD_POL];
			sense_vec[i] = ctrl_ff[i][`MIA_FLD_SENSE];
			pend_vec[i]  = ctrl_ff[i][`MIA_FLD_REQ];
		end
	end

	mia_edge_detect #(
		.N_SRC(N_SRC)
	) u_detect (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.src_in    (src_in),
		.pol_sel   (pol_vec),
		.sense_sel (sense_vec),
		.req_pulse (req_pulse)
	);

	// ==========================================================
	// Arbitration
	always_comb begin
		best_found = 1'b0;
		best_src   = 8'h00;
		best_level = 3'h0;
		offer_ok   = 1'b0;
		for (int i = 0; i < N_SRC; i++) begin
			// Strict compare: level zero never wins, threshold seven blocks all
			if (ctrl_ff[i][`MIA_FLD_REQ] && level_of(ctrl_ff[i]) > threshold_ff &&
				level_of(ctrl_ff[i]) > best_level) begin
				best_found = 1'b1;
				best_src   = 8'(i);
				best_level = level_of(ctrl_ff[i]);
			end
			// Offered source must still qualify at the level it was offered with
			if (irq_source_ff == 8'(i)) begin
				offer_ok = ctrl_ff[i][`MIA_FLD_REQ] && level_of(ctrl_ff[i]) == irq_level_ff &&
					irq_level_ff > threshold_ff;
			end
		end
	end

	// ==========================================================
	// Offer to the core
	assign take_ack = irq_valid && cpu_ack;
	always_comb begin
		for (int i = 0; i < N_SRC; i++) begin
			ack_hit[i] = take_ack && irq_source_ff == 8'(i) && !req_pulse[i];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_ff      <= MIA_IDLE;
			irq_source_ff <= 8'h00;
			irq_level_ff  <= 3'h0;
		end else begin
			unique case (state_ff)
				MIA_IDLE: begin
					if (global_en_ff && best_found) begin
						state_ff      <= MIA_OFFER;
						irq_source_ff <= best_src;
						irq_level_ff  <= best_level;
					end
				end
				MIA_OFFER: begin
					// Back to idle on cpu_ack, global disable or when no source qualifies; otherwise follow the best source
					if (cpu_ack || !global_en_ff || !best_found) begin
						state_ff <= MIA_IDLE;
					end else begin
						irq_source_ff <= best_src;
						irq_level_ff  <= best_level;
					end
				end
			endcase
		end
	end

	assign irq_valid  = (state_ff == MIA_OFFER) && global_en_ff && offer_ok;
	assign irq_source = irq_source_ff;
	assign irq_level  = irq_level_ff;

	// ==========================================================
	// AHB-Lite slave
	assign addr_phase = hsel && hready && htrans[1];
	assign hreadyout  = 1'b1;
	assign hresp      = 1'b0;
	assign hrdata     = hrdata_ff;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_ff <= 1'b0;
			rd_pend_ff <= 1'b0;
			addr_ff    <= 12'h000;
		end else begin
			wr_pend_ff <= addr_phase && hwrite;
			rd_pend_ff <= addr_phase && !hwrite;
			if (addr_phase) begin
				addr_ff <= haddr[11:0];
			end
		end
	end

	// Read data registered in the address phase, zero for unmapped
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_ff <= 32'h0000_0000;
		end else if (addr_phase && !hwrite) begin
			hrdata_ff <= 32'h0000_0000;
			if (haddr[11:0] == `MIA_OFF_GLOBAL) begin
				hrdata_ff <= {31'h0, global_en_ff};
			end else if (haddr[11:0] == `MIA_OFF_THRESHOLD) begin
				hrdata_ff <= {29'h0, threshold_ff};
			end else if (haddr[11:0] == `MIA_OFF_STATUS) begin
				hrdata_ff <= {30'h0, status_ff};
			end else if (haddr[11:0] == `MIA_OFF_MASK) begin
				hrdata_ff <= {30'h0, mask_ff};
			end else if (haddr[11:0] == `MIA_OFF_ACCEPT) begin
				hrdata_ff <= {24'h0, acc_src_ff};
			end else if (is_ctrl(haddr[11:0])) begin
				hrdata_ff <= {24'h0, ctrl_ff[ctrl_idx(haddr[11:0])]};
			end
		end
	end

	// ==========================================================
	// Global enable, threshold and mask
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			global_en_ff <= `MIA_RST_GLOBAL;
			threshold_ff <= `MIA_RST_THRESHOLD;
			mask_ff      <= `MIA_RST_MASK;
		end else if (wr_pend_ff) begin
			if (addr_ff == `MIA_OFF_GLOBAL) begin
				global_en_ff <= hwdata[0];
			end
			if (addr_ff == `MIA_OFF_THRESHOLD) begin
				threshold_ff <= hwdata[2:0];
			end
			if (addr_ff == `MIA_OFF_MASK) begin
				mask_ff <= hwdata[1:0];
			end
		end
	end

	// ==========================================================
	// Source control registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < N_SRC; i++) begin
				ctrl_ff[i] <= `MIA_RST_CTRL;
			end
		end else begin
			for (int i = 0; i < N_SRC; i++) begin
				if (wr_pend_ff && is_ctrl(addr_ff) && ctrl_idx(addr_ff) == i) begin
					ctrl_ff[i][`MIA_FLD_PRIO_MSB:`MIA_FLD_PRIO_LSB] <= hwdata[2:0];
					ctrl_ff[i][`MIA_FLD_POL]   <= hwdata[`MIA_FLD_POL];
					ctrl_ff[i][`MIA_FLD_SENSE] <= hwdata[`MIA_FLD_SENSE];
					ctrl_ff[i][7:6]            <= 2'h0;
					// Zero clears, one leaves alone
					if (!hwdata[`MIA_FLD_REQ]) begin
						ctrl_ff[i][`MIA_FLD_REQ] <= 1'b0;
					end
				end
				if (take_ack && irq_source_ff == 8'(i)) begin
					ctrl_ff[i][`MIA_FLD_REQ] <= 1'b0;
				end
				// New request wins over any clear in the same cycle
				if (req_pulse[i]) begin
					ctrl_ff[i][`MIA_FLD_REQ] <= 1'b1;
				end
			end
		end
	end

	// ==========================================================
	// Event status, mask and interrupt line
	assign any_req = |req_pulse;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			status_ff  <= 2'h0;
			acc_src_ff <= 8'h00;
		end else begin
			// Clear only what the read reported, so an event in the data phase survives
			if (rd_pend_ff && addr_ff == `MIA_OFF_STATUS) begin
				status_ff <= status_ff & ~hrdata_ff[1:0];
			end
			if (any_req) begin
				status_ff[`MIA_EVT_REQ] <= 1'b1;
			end
			if (take_ack) begin
				status_ff[`MIA_EVT_ACC] <= 1'b1;
				acc_src_ff              <= irq_source_ff;
			end
		end
	end

	assign irq_out = |(status_ff & mask_ff);

	// ==========================================================
	// Checks
	property p_no_offer_disabled;
		@(posedge hclk) disable iff (!hresetn)
		!global_en_ff |-> !irq_valid;
	endproperty
	a_no_offer_disabled: assert property (p_no_offer_disabled)
		else $error("offer while globally disabled");

	property p_pend_kept_disabled;
		@(posedge hclk) disable iff (!hresetn)
		!global_en_ff && ctrl_ff[0][`MIA_FLD_REQ] && !wr_pend_ff |=> ctrl_ff[0][`MIA_FLD_REQ];
	endproperty
	a_pend_kept_disabled: assert property (p_pend_kept_disabled)
		else $error("pending bit lost while globally disabled");

	property p_level_above_threshold;
		@(posedge hclk) disable iff (!hresetn)
		irq_valid |-> (irq_level > threshold_ff) && (irq_level != 3'h0);
	endproperty
	a_level_above_threshold: assert property (p_level_above_threshold)
		else $error("offered level not above threshold");

	property p_thr_seven_blocks;
		@(posedge hclk) disable iff (!hresetn)
		(threshold_ff == 3'h7) [*2] |-> !irq_valid;
	endproperty
	a_thr_seven_blocks: assert property (p_thr_seven_blocks)
		else $error("offer with threshold seven");

	property p_req_sets;
		@(posedge hclk) disable iff (!hresetn)
		req_pulse[0] |=> ctrl_ff[0][`MIA_FLD_REQ];
	endproperty
	a_req_sets: assert property (p_req_sets)
		else $error("request did not set pending bit");

	sequence s_ack_taken;
		|ack_hit;
	endsequence
	property p_ack_clears;
		@(posedge hclk) disable iff (!hresetn)
		s_ack_taken |=> (pend_vec & $past(ack_hit)) == '0;
	endproperty
	a_ack_clears: assert property (p_ack_clears)
		else $error("acceptance did not clear pending bit");

	property p_sw_cannot_set;
		@(posedge hclk) disable iff (!hresetn)
		!ctrl_ff[0][`MIA_FLD_REQ] && !req_pulse[0] |=> !ctrl_ff[0][`MIA_FLD_REQ];
	endproperty
	a_sw_cannot_set: assert property (p_sw_cannot_set)
		else $error("pending bit set without a request");

	property p_highest_wins;
		@(posedge hclk) disable iff (!hresetn)
		$rose(irq_valid) |-> irq_level >= level_of(ctrl_ff[0]) ||
			!ctrl_ff[0][`MIA_FLD_REQ] || !$past(ctrl_ff[0][`MIA_FLD_REQ]);
	endproperty
	a_highest_wins: assert property (p_highest_wins)
		else $error("lower level offered over a higher one");

	property p_thr_independent;
		@(posedge hclk) disable iff (!hresetn)
		wr_pend_ff && addr_ff != `MIA_OFF_THRESHOLD |=> $stable(threshold_ff);
	endproperty
	a_thr_independent: assert property (p_thr_independent)
		else $error("threshold changed by another write");

	property p_reset_disabled;
		@(posedge hclk)
		!hresetn |=> !global_en_ff || $past(wr_pend_ff);
	endproperty
	a_reset_disabled: assert property (p_reset_disabled)
		else $error("global enable set after reset");
endmodule

// ### verilog/mia_edge_detect.sv
// Per-source request detector: edge or level, either polarity.
// Assumes source inputs are synchronous to hclk.
`timescale 1ns/1ps
`include "mia_consts.svh"
module mia_edge_detect #(
	parameter int N_SRC = 8
) (
	input  wire logic             hclk,
	input  wire logic             hresetn,
	input  wire logic [N_SRC-1:0] src_in,
	input  wire logic [N_SRC-1:0] pol_sel,
	input  wire logic [N_SRC-1:0] sense_sel,
	output logic      [N_SRC-1:0] req_pulse
);
	logic [N_SRC-1:0] prev_ff;
	logic [N_SRC-1:0] active;

	// ==========================================================
	// History
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			prev_ff <= '0;
		end else begin
			prev_ff <= src_in;
		end
	end

	// ==========================================================
	// Detection
	// Polarity one means rising or high
	assign active = ~(src_in ^ pol_sel);
	// Edge mode needs the previous sample inactive
	assign req_pulse = active & (sense_sel | ~(prev_ff ^ ~pol_sel));
endmodule
